// *** logic/dbgtb_defs.vh ***
// Register offsets, field positions, reset values and mode codes
`ifndef DBGTB_DEFS_VH
`define DBGTB_DEFS_VH

// Register offsets on the plain register port
`define DBGTB_OFS_COMP_A 3'h0
`define DBGTB_OFS_COMP_B 3'h1
`define DBGTB_OFS_CTRL 3'h2
`define DBGTB_OFS_TRIG 3'h3
`define DBGTB_OFS_STAT 3'h4
`define DBGTB_OFS_FIFO 3'h5

// Debug control register fields
`define DBGTB_CTRL_ENABLE 7
`define DBGTB_CTRL_ARM 6
`define DBGTB_CTRL_TAG 5
`define DBGTB_CTRL_CPU_BREAK_ENABLE 4
`define DBGTB_CTRL_RWA 3
`define DBGTB_CTRL_COMP_A_RW_QUALIFY_EN 2
`define DBGTB_CTRL_RWB 1
`define DBGTB_CTRL_COMP_B_RW_QUALIFY_EN 0

// Trigger control register fields
`define DBGTB_TRIG_TRKSEL 7
`define DBGTB_TRIG_BEGIN 6
`define DBGTB_TRIG_MODE_HI 3
`define DBGTB_TRIG_MODE_LO 0

// Debug status register fields
`define DBGTB_STAT_ARMED 7
`define DBGTB_STAT_AFLAG 6
`define DBGTB_STAT_BFLAG 5
`define DBGTB_STAT_CNT_HI 3
`define DBGTB_STAT_CNT_LO 0

// Reset values
`define DBGTB_RST_COMP 16'h0000
`define DBGTB_RST_CTRL 8'h00
`define DBGTB_RST_TRIG 8'h00

// Trigger mode codes
`define DBGTB_MODE_A_ONLY 4'h0
`define DBGTB_MODE_A_OR_B 4'h1
`define DBGTB_MODE_A_THEN_B 4'h2
`define DBGTB_MODE_EVT_B 4'h3
`define DBGTB_MODE_A_THEN_EVT_B 4'h4
`define DBGTB_MODE_A_AND_B 4'h5
`define DBGTB_MODE_A_NOT_B 4'h6
`define DBGTB_MODE_INSIDE 4'h7
`define DBGTB_MODE_OUTSIDE 4'h8

`endif

// *** logic/dbgtb_trigger_break.v ***
// Debug trigger, opcode tracking, capture buffer and breakpoint requests
// Contract
// - Tag acts only if tagged opcode executes
// - Force break waits for instruction completion
// - Tag marker travels with opcode
// - Track select routes matches via tracker
// - Separate opcode tracker per comparator
// - Mode field selects one of nine modes
// - Begin bit picks begin or end trace
// - Arm write sets armed, clears count; flags clear unless a same-cycle match sets them
// - Begin run ends full; end run at trigger
// - Writing zero to arm or enable stops
// - Flow addresses; event modes store byte
// - Event-only modes act as begin trace
// - Optional read/write qualification per comparator
// - Break enable raises tag or force request
// - A-only and A-or-B address matching
// - A-then-B needs an earlier A match
// - Full mode: address A, data B, same cycle
// - Full not mode: address A, data differs
// - Full mode tag request uses address A only
// - Event-only B stores data, ends when full
// - Inside and outside range comparisons
// - No background permit: software interrupt
// - 16-bit comparators; B checks address or data
// - Write data bus when A qualifies writes
// - Comparators idle during debug accesses
`timescale 1ns/1ps
`default_nettype none
`include "dbgtb_defs.vh"

module dbgtb_trigger_break #(
    parameter AW = 16,  // Comparator and address width
    parameter DEPTH = 8  // Capture buffer words
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register port
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    output reg [15:0] reg_rdata_q,
    // CPU bus cycle
    input wire bus_valid,
    input wire [AW-1:0] cpu_addr,
    input wire cpu_rw,
    input wire [7:0] cpu_rdata,
    input wire [7:0] cpu_wdata,
    input wire bdc_access,
    // Instruction queue events
    input wire op_fetch,
    input wire op_exec,
    input wire [AW-1:0] op_exec_addr,
    input wire queue_flush,
    input wire instr_boundary,
    // Change-of-flow address source
    input wire cof_valid,
    input wire [AW-1:0] cof_addr,
    // Background permission from serial controller
    input wire background_permit,
    // Breakpoint requests to the CPU and run state
    output reg brk_tag_q,
    output reg brk_force_q,
    output reg brk_use_swi_q,
    output reg armed_q
);

    // One-hot run states
    localparam [2:0] ST_IDLE = 3'b001;  // Not armed
    localparam [2:0] ST_WAIT = 3'b010;  // Armed, waiting for trigger
    localparam [2:0] ST_CAPT = 3'b100;  // Begin trace storing
    localparam [3:0] FULL_CNT = DEPTH;  // Count at full buffer

    // Programmed comparators and control bytes
    reg [AW-1:0] comp_a_q;  // Comparator A value
    reg [AW-1:0] comp_b_q;  // Comparator B value
    reg [7:0] debug_control_reg_q;  // Enable, arm, tag, break, r/w
    reg [7:0] trigger_control_reg_q;  // Track select, begin, mode
    // Run state and status
    reg [2:0] state_q;  // Current run state
    reg comp_a_match_flag_q;  // Sticky A match
    reg comp_b_match_flag_q;  // Sticky B match
    reg a_seen_q;  // A matched in an earlier cycle
    reg [3:0] buffer_word_count_q;  // Valid words held
    reg [15:0] fifo_q [0:DEPTH-1];  // Capture storage
    // Opcode trackers, one per comparator
    reg [1:0] trk_valid_q;  // Tracker holds a fetched opcode
    reg [AW-1:0] trk_addr_q [0:1];  // Address of tracked opcode
    reg force_pend_q;  // Force request awaiting boundary
    integer i;

    // Returns 1 if r/w qualification passes
    function rw_ok;
        input en;
        input val;
        input rw;
        begin
            rw_ok = ~en | (rw == val);
        end
    endfunction

    // Combines comparator events into a trigger for the mode
    function mode_trig;
        input [3:0] mode;
        input ev_a;
        input ev_b;
        input seen;
        begin
            case (mode)
                `DBGTB_MODE_A_OR_B: mode_trig = ev_a | ev_b;
                `DBGTB_MODE_A_THEN_B: mode_trig = ev_b & seen;
                `DBGTB_MODE_EVT_B: mode_trig = ev_b;
                `DBGTB_MODE_A_THEN_EVT_B: mode_trig = ev_b & seen;
                default: mode_trig = ev_a;  // A-only, full, range, unused
            endcase
        end
    endfunction

    // Control field decode
    wire dbg_en = debug_control_reg_q[`DBGTB_CTRL_ENABLE];
    wire tag_sel = debug_control_reg_q[`DBGTB_CTRL_TAG];
    wire cpu_break_enable = debug_control_reg_q[`DBGTB_CTRL_CPU_BREAK_ENABLE];
    wire comp_a_rw_value = debug_control_reg_q[`DBGTB_CTRL_RWA];
    wire comp_a_rw_qualify_en = debug_control_reg_q[`DBGTB_CTRL_COMP_A_RW_QUALIFY_EN];
    wire comp_b_rw_value = debug_control_reg_q[`DBGTB_CTRL_RWB];
    wire comp_b_rw_qualify_en = debug_control_reg_q[`DBGTB_CTRL_COMP_B_RW_QUALIFY_EN];
    wire trk_sel = trigger_control_reg_q[`DBGTB_TRIG_TRKSEL];
    wire begin_bit = trigger_control_reg_q[`DBGTB_TRIG_BEGIN];
    wire [3:0] mode = trigger_control_reg_q[`DBGTB_TRIG_MODE_HI:
        `DBGTB_TRIG_MODE_LO];

    // Mode classes
    wire is_event = (mode == `DBGTB_MODE_EVT_B) |
        (mode == `DBGTB_MODE_A_THEN_EVT_B);
    wire is_full = (mode == `DBGTB_MODE_A_AND_B) |
        (mode == `DBGTB_MODE_A_NOT_B);
    // Event-only runs are always begin type
    wire begin_trace = begin_bit | is_event;

    // Comparators ignore debug accesses
    wire cmp_live = bus_valid & ~bdc_access;
    // Data bus pick for full modes
    wire [7:0] cmp_data = (comp_a_rw_qualify_en & ~comp_a_rw_value) ? cpu_wdata : cpu_rdata;
    wire a_rw = rw_ok(comp_a_rw_qualify_en, comp_a_rw_value, cpu_rw);
    wire b_rw = rw_ok(comp_b_rw_qualify_en, comp_b_rw_value, cpu_rw);
    wire addr_a = cmp_live & (cpu_addr == comp_a_q) & a_rw;
    wire addr_b = cmp_live & (cpu_addr == comp_b_q) & b_rw;
    wire data_b = (cmp_data == comp_b_q[7:0]);

    // Per-mode A-side condition
    reg cond_a;
    always @* begin
        case (mode)
            `DBGTB_MODE_A_AND_B: cond_a = addr_a & data_b;
            `DBGTB_MODE_A_NOT_B: cond_a = addr_a & ~data_b;
            `DBGTB_MODE_INSIDE: cond_a = cmp_live & a_rw &
                (cpu_addr >= comp_a_q) & (cpu_addr <= comp_b_q);
            `DBGTB_MODE_OUTSIDE: cond_a = cmp_live & a_rw &
                ((cpu_addr < comp_a_q) | (cpu_addr > comp_b_q));
            default: cond_a = addr_a;
        endcase
    end
    // B compares address only outside full and range modes
    wire cond_b = addr_b & ~is_full & (mode != `DBGTB_MODE_INSIDE) &
        (mode != `DBGTB_MODE_OUTSIDE);

    // Tracked hits: matched opcode executed
    wire trk_hit_a = op_exec & trk_valid_q[0] &
        (op_exec_addr == trk_addr_q[0]);
    wire trk_hit_b = op_exec & trk_valid_q[1] &
        (op_exec_addr == trk_addr_q[1]);
    wire ev_a = trk_sel ? trk_hit_a : cond_a;
    wire ev_b = trk_sel ? trk_hit_b : cond_b;

    // Qualified trigger for the run
    wire run_on = state_q != ST_IDLE;
    wire trig = run_on & mode_trig(mode, ev_a, ev_b, a_seen_q);

    // Tag condition: raw fetch match, full modes A alone
    wire tag_cond = is_full ? addr_a :
        mode_trig(mode, cond_a, cond_b, a_seen_q);

    // Register port decode
    wire wr_ctrl = reg_we & (reg_addr == `DBGTB_OFS_CTRL);
    wire arm_write = wr_ctrl & reg_wdata[`DBGTB_CTRL_ARM] &
        reg_wdata[`DBGTB_CTRL_ENABLE];
    wire stop_write = wr_ctrl & (~reg_wdata[`DBGTB_CTRL_ARM] |
        ~reg_wdata[`DBGTB_CTRL_ENABLE]);
    wire fifo_rd = reg_re & (reg_addr == `DBGTB_OFS_FIFO);

    // Capture decision and word stored
    wire full = buffer_word_count_q == FULL_CNT;
    reg push;
    reg [15:0] push_data;
    always @* begin
        push = 1'b0;
        push_data = cof_addr;
        if (is_event) begin
            // Event modes store the data byte on each trigger
            push = (state_q == ST_WAIT) & trig & ~full;
            push_data = {8'h00, cmp_data};
        end else if (begin_trace) begin
            push = (state_q == ST_CAPT) & cof_valid & ~full;
        end else begin
            // End trace stores circularly while waiting
            push = (state_q == ST_WAIT) & cof_valid;
        end
    end
    // No pops while a run is storing
    wire pop = fifo_rd & (buffer_word_count_q != 4'h0) & ~run_on;
    wire fills = push & (buffer_word_count_q == FULL_CNT - 4'h1);
    // Self-ending run, so the armed output drops with the state
    wire run_end = (state_q == ST_CAPT | is_event) & fills |
        (state_q == ST_WAIT & ~is_event & trig & ~begin_trace);

    // Software-written registers; arm bit also drops when run ends
    always @(posedge clk) begin
        if (sys_rst) begin
            comp_a_q <= `DBGTB_RST_COMP;
            comp_b_q <= `DBGTB_RST_COMP;
            debug_control_reg_q <= `DBGTB_RST_CTRL;
            trigger_control_reg_q <= `DBGTB_RST_TRIG;
        end else begin
            if (reg_we && reg_addr == `DBGTB_OFS_COMP_A) begin
                comp_a_q <= reg_wdata[AW-1:0];
            end
            if (reg_we && reg_addr == `DBGTB_OFS_COMP_B) begin
                comp_b_q <= reg_wdata[AW-1:0];
            end
            if (reg_we && reg_addr == `DBGTB_OFS_TRIG) begin
                trigger_control_reg_q <= reg_wdata[7:0];
            end
            if (wr_ctrl) begin
                debug_control_reg_q <= reg_wdata[7:0];
            end else if (state_q == ST_IDLE) begin
                // Self-ended run reads back disarmed
                debug_control_reg_q[`DBGTB_CTRL_ARM] <= 1'b0;
            end
        end
    end

    // Run state machine
    always @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else if (arm_write) begin
            state_q <= ST_WAIT;
        end else if (stop_write) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_WAIT: begin
                    if (is_event) begin
                        if (fills) begin
                            state_q <= ST_IDLE;
                        end
                    end else if (trig) begin
                        // Begin trace starts; end trace stops
                        state_q <= begin_trace ? ST_CAPT : ST_IDLE;
                    end
                end
                ST_CAPT: begin
                    if (fills) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Sticky match flags and A-seen memory; a match beats arm clear
    always @(posedge clk) begin
        if (sys_rst) begin
            comp_a_match_flag_q <= 1'b0;
            comp_b_match_flag_q <= 1'b0;
            a_seen_q <= 1'b0;
        end else begin
            if (run_on && ev_a) begin
                comp_a_match_flag_q <= 1'b1;
                a_seen_q <= 1'b1;
            end else if (arm_write) begin
                comp_a_match_flag_q <= 1'b0;
                a_seen_q <= 1'b0;
            end
            if (run_on && ev_b) begin
                comp_b_match_flag_q <= 1'b1;
            end else if (arm_write) begin
                comp_b_match_flag_q <= 1'b0;
            end
        end
    end

    // Capture buffer: append, circular overwrite, or pop on read
    always @(posedge clk) begin
        if (sys_rst) begin
            buffer_word_count_q <= 4'h0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                fifo_q[i] <= 16'h0000;
            end
        end else if (arm_write) begin
            buffer_word_count_q <= 4'h0;
        end else if (push && full) begin
            // End trace wrap: drop oldest, keep newest last
            for (i = 0; i < DEPTH - 1; i = i + 1) begin
                fifo_q[i] <= fifo_q[i+1];
            end
            fifo_q[DEPTH-1] <= push_data;
        end else if (push) begin
            fifo_q[buffer_word_count_q[2:0]] <= push_data;
            buffer_word_count_q <= buffer_word_count_q + 4'h1;
        end else if (pop) begin
            for (i = 0; i < DEPTH - 1; i = i + 1) begin
                fifo_q[i] <= fifo_q[i+1];
            end
            buffer_word_count_q <= buffer_word_count_q - 4'h1;
        end
    end

    // Opcode trackers, one pending opcode each
    always @(posedge clk) begin
        if (sys_rst) begin
            trk_valid_q <= 2'b00;
            trk_addr_q[0] <= {AW{1'b0}};
            trk_addr_q[1] <= {AW{1'b0}};
        end else if (queue_flush) begin
            trk_valid_q <= 2'b00;
        end else begin
            // Comparator A tracker
            if (op_fetch && cond_a) begin
                trk_valid_q[0] <= 1'b1;
                trk_addr_q[0] <= cpu_addr;
            end else if (trk_hit_a) begin
                trk_valid_q[0] <= 1'b0;
            end
            // Comparator B tracker, independent of A
            if (op_fetch && cond_b) begin
                trk_valid_q[1] <= 1'b1;
                trk_addr_q[1] <= cpu_addr;
            end else if (trk_hit_b) begin
                trk_valid_q[1] <= 1'b0;
            end
        end
    end

    // Breakpoint requests to the CPU
    always @(posedge clk) begin
        if (sys_rst) begin
            brk_tag_q <= 1'b0;
            brk_force_q <= 1'b0;
            brk_use_swi_q <= 1'b0;
            force_pend_q <= 1'b0;
        end else begin
            // Tag marks the fetched opcode
            brk_tag_q <= cpu_break_enable & tag_sel & run_on & op_fetch &
                tag_cond;
            // Force waits for the end of the current instruction
            if (cpu_break_enable && !tag_sel && trig) begin
                force_pend_q <= 1'b1;
            end else if (instr_boundary) begin
                force_pend_q <= 1'b0;
            end
            brk_force_q <= force_pend_q & instr_boundary;
            // Break opcode choice when background is not permitted
            brk_use_swi_q <= ~background_permit;
        end
    end

    // Status and read port; data one cycle after the read strobe
    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata_q <= 16'h0000;
            armed_q <= 1'b0;
        end else begin
            armed_q <= arm_write | (run_on & ~stop_write & ~run_end);
            case (reg_addr)
                `DBGTB_OFS_COMP_A: reg_rdata_q <= comp_a_q;
                `DBGTB_OFS_COMP_B: reg_rdata_q <= comp_b_q;
                `DBGTB_OFS_CTRL: reg_rdata_q <= {8'h00,
                    debug_control_reg_q};
                `DBGTB_OFS_TRIG: reg_rdata_q <= {8'h00,
                    trigger_control_reg_q};
                `DBGTB_OFS_STAT: reg_rdata_q <= {8'h00, run_on,
                    comp_a_match_flag_q, comp_b_match_flag_q, 1'b0,
                    buffer_word_count_q};
                `DBGTB_OFS_FIFO: reg_rdata_q <= fifo_q[0];
                default: reg_rdata_q <= 16'h0000;  // Unmapped reads zero
            endcase
            if (!reg_re) begin
                reg_rdata_q <= 16'h0000;
            end
        end
    end

endmodule // dbgtb_trigger_break
`default_nettype wire

// *** sim/dbgtb_chk.sv ***
// Port checker for the debug trigger and breakpoint block
`timescale 1ns/1ps
`default_nettype none
module dbgtb_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [15:0] reg_rdata_q,
    // Core side inputs
    input wire logic bus_valid,
    input wire logic bdc_access,
    input wire logic op_fetch,
    input wire logic instr_boundary,
    input wire logic background_permit,
    // Requests and run state
    input wire logic brk_tag_q,
    input wire logic brk_force_q,
    input wire logic brk_use_swi_q,
    input wire logic armed_q
);
    // Control write decode
    wire ctl_wr = reg_we && reg_addr == 3'h2;
    // Arm needs enable too
    wire arm_wr = ctl_wr && reg_wdata[7:6] == 2'b11;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    arm_start_a: assert property (arm_wr |=> armed_q)
        else $error("arm did not start run");
    stop_write_a: assert property (ctl_wr && !arm_wr |=> !armed_q)
        else $error("run not stopped");
    status_armed_a: assert property (reg_re && reg_addr == 3'h4
        |=> reg_rdata_q[7] == $past(armed_q) && reg_rdata_q[15:8] == 8'h00)
        else $error("status misses run state");
    tag_on_fetch_a: assert property (brk_tag_q |-> $past(op_fetch && bus_valid))
        else $error("tag pulse without an opcode fetch");
    tag_bdc_quiet_a: assert property (brk_tag_q |-> !$past(bdc_access))
        else $error("tag pulse from a debug access");
    tag_in_run_a: assert property (brk_tag_q |-> $past(armed_q))
        else $error("tag pulse outside a run");
    force_boundary_a: assert property (brk_force_q |-> $past(instr_boundary))
        else $error("force pulse not after an instruction end");
    swi_select_a: assert property (!$past(sys_rst)
        |-> brk_use_swi_q == !$past(background_permit))
        else $error("fallback does not follow permit");
endmodule // dbgtb_chk
`default_nettype wire

// *** sim/dbgtb_cpu_model.sv ***
// Behavioural core model: bus cycles and instruction queue events
`timescale 1ns/1ps
`default_nettype none
module dbgtb_cpu_model (
    // Clock
    input wire logic clk,
    // Bus cycle
    output logic bus_valid,
    output logic [15:0] cpu_addr,
    output logic cpu_rw,
    output logic [7:0] cpu_rdata,
    output logic [7:0] cpu_wdata,
    output logic bdc_access,
    // Queue events
    output logic op_fetch,
    output logic op_exec,
    output logic [15:0] op_exec_addr,
    output logic queue_flush,
    output logic instr_boundary,
    // Flow addresses, never offered here
    output logic cof_valid,
    output logic [15:0] cof_addr
);
    logic [15:0] last_a = 16'h0000; // Last address shown
    logic [7:0] last_d = 8'h00; // Last data shown

    // Quiet core at time zero
    initial begin
        {bus_valid, cpu_rw, bdc_access, op_fetch, op_exec} = 5'h00;
        {queue_flush, instr_boundary, cof_valid} = 3'h0;
        {cpu_addr, op_exec_addr, cof_addr} = 48'h0;
        {cpu_rdata, cpu_wdata} = 16'h0;
    end

    // One core clock; idle lines show inverted values
    task automatic step(input logic v, input logic [15:0] a,
                        input logic [7:0] d, input logic f,
                        input logic b, input logic [2:0] k);
        last_a = v ? a : ~last_a;
        last_d = v ? d : ~last_d;
        bus_valid <= v;
        cpu_addr <= last_a;
        cpu_rw <= v | ~cpu_rw;
        cpu_rdata <= last_d;
        cpu_wdata <= ~last_d;
        op_fetch <= f;
        bdc_access <= b;
        {queue_flush, instr_boundary, op_exec} <= k;
        op_exec_addr <= a;
        cof_addr <= ~last_a;
        @(posedge clk);
    endtask
endmodule // dbgtb_cpu_model
`default_nettype wire

// *** sim/dbgtb_trigger_break_test.sv ***
// Self-checking bench for the debug trigger and breakpoint block
`timescale 1ns/1ps
`default_nettype none
`include "dbgtb_defs.vh"
module dbgtb_trigger_break_test;
    localparam logic [15:0] CA = 16'h1000; // Comparator A value
    localparam logic [15:0] CB = 16'h2055; // Comparator B value
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic background_permit = 1'b0;
    wire [15:0] reg_rdata_q, cpu_addr, op_exec_addr, cof_addr;
    wire [7:0] cpu_rdata, cpu_wdata;
    wire bus_valid, cpu_rw, bdc_access, op_fetch, op_exec, queue_flush;
    wire instr_boundary, cof_valid;
    wire brk_tag_q, brk_force_q, brk_use_swi_q, armed_q;
    int error_cnt = 0;
    int checks_done = 0;
    int tcnt = 0; // Tag pulses seen
    int fcnt = 0; // Force pulses seen
    int seed, base;
    logic [15:0] v;
    logic [7:0] d8 [8];

    dbgtb_trigger_break #(.AW(16), .DEPTH(8)) i_dbgtb_trigger_break (
        .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_we, .reg_re,
        .reg_rdata_q, .bus_valid, .cpu_addr, .cpu_rw, .cpu_rdata,
        .cpu_wdata, .bdc_access, .op_fetch, .op_exec, .op_exec_addr,
        .queue_flush, .instr_boundary, .cof_valid, .cof_addr,
        .background_permit, .brk_tag_q, .brk_force_q, .brk_use_swi_q,
        .armed_q);
    dbgtb_cpu_model i_dbgtb_cpu_model (
        .clk, .bus_valid, .cpu_addr, .cpu_rw, .cpu_rdata, .cpu_wdata,
        .bdc_access, .op_fetch, .op_exec, .op_exec_addr, .queue_flush,
        .instr_boundary, .cof_valid, .cof_addr);

    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end
    // Random permission keeps fallback moving
    always @(posedge clk) begin
        background_permit <= 1'($random(seed));
    end
    // Pulses counted mid-cycle, clear of edge races
    always @(negedge clk) begin
        tcnt += brk_tag_q;
        fcnt += brk_force_q;
    end

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Register write, one gap cycle
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        @(posedge clk);
    endtask
    // Register read; data the cycle after
    task automatic rd(input logic [2:0] a, output logic [15:0] r);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        @(negedge clk);
        r = reg_rdata_q;
        @(posedge clk);
    endtask
    // Bus cycle and queue event shorthands
    task automatic cy(input logic [15:0] a, input logic [7:0] d,
                      input logic f, input logic b);
        i_dbgtb_cpu_model.step(1'b1, a, d, f, b, 3'h0);
    endtask
    task automatic ev(input logic [2:0] k, input logic [15:0] a);
        i_dbgtb_cpu_model.step(1'b0, a, 8'h00, 1'b0, 1'b0, k);
    endtask
    // Corner addresses around both comparators
    function automatic logic [15:0] pick();
        logic [31:0] r;
        r = $random(seed);
        case (r[1:0])
            2'h0: pick = CA;
            2'h1: pick = CB;
            2'h2: pick = CA - 16'h0001;
            default: pick = CB + 16'h0001;
        endcase
    endfunction
    // Expected trigger of one read cycle
    function automatic logic hit(input logic [3:0] m, input logic [15:0] a,
                                 input logic [7:0] d, input logic q,
                                 input logic seen);
        logic ea;
        ea = !q && a == CA;
        case (m)
            `DBGTB_MODE_A_OR_B: hit = ea || a == CB;
            `DBGTB_MODE_A_THEN_B: hit = seen && a == CB;
            `DBGTB_MODE_A_AND_B: hit = ea && d == CB[7:0];
            `DBGTB_MODE_A_NOT_B: hit = ea && d != CB[7:0];
            `DBGTB_MODE_INSIDE: hit = !q && a >= CA && a <= CB;
            `DBGTB_MODE_OUTSIDE: hit = !q && (a < CA || a > CB);
            default: hit = ea;
        endcase
    endfunction
    // Force trial: two cycles, then a boundary
    task automatic trial(input logic [3:0] m, input logic q);
        logic [15:0] a0, a1;
        logic [7:0] d0, d1;
        logic e;
        a0 = pick();
        a1 = pick();
        d0 = $random(seed) & 1 ? CB[7:0] : 8'($random(seed));
        d1 = $random(seed) & 1 ? CB[7:0] : 8'($random(seed));
        e = hit(m, a0, d0, q, 1'b0) || hit(m, a1, d1, q, !q && a0 == CA);
        wr(3'h3, {12'h004, m});
        wr(3'h2, q ? 16'h00d4 : 16'h00d0);
        base = fcnt;
        cy(a0, d0, 1'b0, 1'b0);
        cy(a1, d1, 1'b0, 1'b0);
        ev(3'b010, 16'h0000);
        ev(3'b000, 16'h0000);
        ev(3'b000, 16'h0000);
        chk(16'(fcnt - base), {15'h0000, e});
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("[ERR] %0t run limit reached", $time);
        results();
    end

    // Main sequence
    initial begin
        seed = 32'h1d38;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Reset values, unmapped offsets read zero
        for (int i = 0; i < 8; i++) begin
            if (i < 4 || i > 5) begin
                rd(3'(i), v);
                chk(v, 16'h0000);
            end
        end
        wr(3'h0, CA);
        wr(3'h1, CB);
        // Tags: raw fetch match, data ignored, debug access dead
        for (int i = 0; i < 2; i++) begin
            wr(3'h3, i ? 16'h0005 : 16'h0000);
            wr(3'h2, 16'h00f0);
            base = tcnt;
            cy(CA, 8'h00, 1'b1, 1'b0);
            cy(CA, 8'h00, 1'b1, 1'b1);
            cy(CB, 8'h00, 1'b1, 1'b0);
            ev(3'b000, 16'h0000);
            chk(16'(tcnt - base), 16'h0001);
        end
        // Tracking: flushed opcodes do nothing
        wr(3'h3, 16'h0081);
        wr(3'h2, 16'h00d0);
        base = fcnt;
        cy(CA, 8'h00, 1'b1, 1'b0);
        cy(CB, 8'h00, 1'b1, 1'b0);
        ev(3'b100, 16'h0000);
        ev(3'b010, 16'h0000);
        ev(3'b000, 16'h0000);
        chk(16'(fcnt - base), 16'h0000);
        cy(CA, 8'h00, 1'b1, 1'b0);
        cy(CB, 8'h00, 1'b1, 1'b0);
        ev(3'b001, CB);
        ev(3'b010, 16'h0000);
        ev(3'b000, 16'h0000);
        chk(16'(fcnt - base), 16'h0001);
        // All modes but the event-only ones (3 and 4), then random ones
        for (int n = 0; n < 48; n++) begin
            v = n < 16 ? 16'(n) : 16'($random(seed));
            if (v[3:0] != 4'h3 && v[3:0] != 4'h4)
                trial(v[3:0], n > 15 && v[4]);
        end
        // Event capture ends when full
        wr(3'h3, 16'h0003);
        wr(3'h2, 16'h00c0);
        for (int i = 0; i < 8; i++) begin
            d8[i] = 8'($random(seed));
            cy(CB, d8[i], 1'b0, 1'b0);
            ev(3'b000, 16'h0000);
            rd(3'h4, v);
            chk(v & 16'h0080, i < 7 ? 16'h0080 : 16'h0000);
        end
        rd(3'h4, v);
        chk(v & 16'h008f, 16'h0008);
        for (int i = 0; i < 8; i++) begin
            rd(3'h5, v);
            chk(v, {8'h00, d8[i]});
        end
        // Re-arm clears the B flag; the count was already emptied by reads
        wr(3'h2, 16'h00c0);
        rd(3'h4, v);
        chk(v, 16'h0080);
        // End trace stops at its trigger
        wr(3'h3, 16'h0000);
        wr(3'h2, 16'h00c0);
        cy(CA, 8'h00, 1'b0, 1'b0);
        ev(3'b000, 16'h0000);
        rd(3'h4, v);
        chk(v & 16'h0080, 16'h0000);
        // Clearing enable or arm stops a run
        for (int i = 0; i < 2; i++) begin
            wr(3'h2, 16'h00c0);
            wr(3'h2, i ? 16'h0080 : 16'h0040);
            rd(3'h4, v);
            chk(v & 16'h0080, 16'h0000);
        end
        results();
    end
endmodule // dbgtb_trigger_break_test

bind dbgtb_trigger_break dbgtb_chk i_dbgtb_chk (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata_q,
    .bus_valid, .bdc_access, .op_fetch, .instr_boundary,
    .background_permit, .brk_tag_q, .brk_force_q, .brk_use_swi_q,
    .armed_q);
`default_nettype wire
